// ### dv/host_model.sv
// Purpose: host end of the serial link, sends frames of whole conversions
// Assumes: serial period of eight system clocks, pins change at falling clock edge
// Notes: serial clock stands still between frames so the converter can sleep
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clock,
  output logic csN,
  output logic sclk,
  output logic din,
  input wire logic doutPin,
  output logic wordValid,
  output logic [15:0] wordData
);
  // idle link at time zero
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    wordValid = 1'b0;
    wordData = 16'h0000;
  end

  // half a serial period
  task automatic half();
    repeat (4) @(negedge clock);
  endtask : half

  // one control word per conversion, sixteen rises each
  // start 0: clock idles low; 1: clock falls with select; 2: clock falls half a period after select
  task automatic frame(input logic [7:0] ctrl[$], input logic [1:0] start);
    logic [15:0] rx;
    rx = 16'h0000;
    if (start != 2'h0) begin
      sclk = 1'b1;
      half();
    end
    csN = 1'b0;
    if (start == 2'h2) half(); // clock still high: track starts only at its later fall
    sclk = 1'b0; // both fall together when start is 1
    foreach (ctrl[c]) begin
      for (int k = 0; k < 16; k++) begin
        din = (k < 8) ? ctrl[c][7 - k] : 1'($urandom); // picks the following conversion
        half();
        sclk = 1'b1;
        half();
        rx = {rx[14:0], doutPin}; // read late in the period, well settled
        if (k < 15 || c < ctrl.size() - 1) sclk = 1'b0;
      end
      wordData = rx;
      wordValid = 1'b1;
      @(negedge clock);
      wordValid = 1'b0;
    end
    half();
    csN = 1'b1; // fewer conversions, idle between frames
    half();
    sclk = 1'b0;
  endtask : frame
endmodule : host_model
`default_nettype wire

// ### dv/test_dual_adc_serial_ctrl.sv
// Purpose: self-checking bench of the converter serial control
// Assumes: host model drives the link, an inline core model answers sample requests
// Notes: expected words and channels are queued in issue order
`timescale 1ns/1ps
`default_nettype none
module test_dual_adc_serial_ctrl;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic csN, sclk, din, doutO, doutOe, doutPin, trackMode, powerDown, sampleReq, convReady;
  logic lastBit = 1'b0;
  logic convValid = 1'b0;
  logic [11:0] convData = 12'h000;
  logic stall = 1'b0;
  logic wordValid;
  logic [15:0] wordData;
  int trackCnt = 0;
  int failures = 0;
  int tests_run = 0;
  adc_ctrl_pkg::chan_t chanSel, sampleChan;
  adc_ctrl_pkg::chan_t pend = adc_ctrl_pkg::CHAN_A;
  adc_ctrl_pkg::chan_t chanQ[$];
  adc_ctrl_pkg::chan_t expChan = adc_ctrl_pkg::CHAN_A;
  logic [15:0] expQ[$];

  always #25 clock = ~clock;
  // a released line drifts away from its last driven level
  assign doutPin = doutOe ? doutO : ~lastBit;
  always @(posedge clock) if (doutOe === 1'b1) lastBit <= doutO;

  dual_adc_serial_ctrl dut (.clock(clock), .nrst(nrst), .csN(csN), .sclk(sclk), .din(din), .doutO(doutO),
    .doutOe(doutOe), .chanSel(chanSel), .trackMode(trackMode), .powerDown(powerDown), .sampleReq(sampleReq),
    .sampleChan(sampleChan), .convData(convData), .convValid(convValid), .convReady(convReady));
  host_model host (.clock(clock), .csN(csN), .sclk(sclk), .din(din), .doutPin(doutPin),
    .wordValid(wordValid), .wordData(wordData));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // core hands one result word; held until the buffer takes it
  task automatic push(input logic [11:0] d);
    convData = d;
    convValid = 1'b1;
    expQ.push_back({4'h0, d});
    while (convReady !== 1'b1) @(negedge clock);
    @(negedge clock);
    convValid = 1'b0;
  endtask : push

  // one frame of n conversions with random control words
  task automatic run(input int n, input logic [1:0] start);
    logic [7:0] ctrl[$];
    logic [7:0] w;
    for (int i = 0; i < n; i++) begin
      w = 8'($urandom) & 8'hef; // loose bits random, bit 4 kept clear
      ctrl.push_back(w);
      chanQ.push_back(pend);
      pend = w[3] ? adc_ctrl_pkg::CHAN_B : adc_ctrl_pkg::CHAN_A;
    end
    host.frame(ctrl, start);
    repeat (8) @(negedge clock);
    check(16'(doutOe), 16'h0000);
    check(16'(powerDown), 16'h0001);
    $display("test done: %0d conversions, mismatches so far %0d", n, failures);
  endtask : run

  // track length, power and channel seen at each hold request
  always @(posedge clock) begin
    if (trackMode === 1'b1) trackCnt <= trackCnt + 1;
    if (sampleReq === 1'b1) begin
      check(16'(trackCnt >= 23 && trackCnt <= 25), 16'h0001);
      check(16'(powerDown), 16'h0000);
      expChan = chanQ.pop_front();
      check(16'(sampleChan), 16'(expChan));
      check(16'(chanSel), 16'(expChan));
      trackCnt <= 0;
    end
  end

  // core model answers promptly unless stalled
  initial forever begin
    @(posedge clock);
    if (sampleReq === 1'b1 && !stall) begin
      @(negedge clock);
      push(12'($urandom));
    end
  end

  // each finished word against the oldest note
  always @(posedge clock) begin
    if (wordValid === 1'b1) check(wordData, expQ.pop_front());
  end

  // stops a hung run
  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(17412));
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    check(16'(powerDown), 16'h0001);
    check(16'(doutOe), 16'h0000);
    check(16'(convReady), 16'h0001);
    run(1, 2'h0);
    run(3, 2'h0);
    run(2, 2'h1);
    run(2, 2'h2);
    // fill the buffer while the core ignores requests
    stall = 1'b1;
    for (int i = 0; i < 32; i++) begin
      push(12'($urandom));
      @(negedge clock);
    end
    check(16'(convReady), 16'h0000);
    run(16, 2'h0);
    run(16, 2'h1);
    check(16'(convReady), 16'h0001);
    expQ.push_back(16'h0000); // empty buffer sends zeros
    run(1, 2'h0);
    stall = 1'b0;
    run(2, 2'h2);
    tally_and_finish();
  end
endmodule : test_dual_adc_serial_ctrl
`default_nettype wire

// ### hdl/dual_adc_serial_ctrl.sv
// Purpose: serial control of a two-input twelve-bit converter
// Assumes: frame select, serial clock and serial input come from the host, async to clock
// Notes: serial clock is sampled, not used as a clock; it must run well below clock/4
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module dual_adc_serial_ctrl (
  input wire logic clock,
  input wire logic nrst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  output logic doutO,
  output logic doutOe,
  output adc_ctrl_pkg::chan_t chanSel,
  output logic trackMode,
  output logic powerDown,
  output logic sampleReq,
  output adc_ctrl_pkg::chan_t sampleChan,
  input wire logic [`RES_WIDTH-1:0] convData,
  input wire logic convValid,
  output logic convReady
);
  logic csMeta;
  logic csSync;
  logic csLast;
  logic sclkMeta;
  logic sclkSync;
  logic sclkLast;
  logic dinMeta;
  logic dinSync;
  logic sclkRise;
  logic sclkFall;
  logic frameStart;
  logic [4:0] cycle;
  logic [4:0] next_cycle;
  logic [3:0] riseCnt;
  logic [3:0] next_riseCnt;
  logic [`CTRL_WIDTH-1:0] inputSelectControl;
  logic [`CTRL_WIDTH-1:0] next_inputSelectControl;
  adc_ctrl_pkg::chan_t pendingChan;
  adc_ctrl_pkg::chan_t next_pendingChan;
  adc_ctrl_pkg::chan_t activeChan;
  adc_ctrl_pkg::chan_t next_activeChan;
  adc_ctrl_pkg::chan_t next_sampleChan;
  adc_ctrl_pkg::phase_t phase;
  logic [`RES_WIDTH-1:0] shifter;
  logic [`RES_WIDTH-1:0] next_shifter;
  logic next_doutO;
  logic next_sampleReq;
  logic popValid;
  logic popReady;
  logic [`RES_WIDTH-1:0] popData;
  logic everCommit;
  logic [`CTRL_WIDTH-1:0] word;

  // two-stage synchronisers; edge detection reads only the second stage onward
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      csMeta <= 1'b1;
      csSync <= 1'b1;
      csLast <= 1'b1;
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkLast <= 1'b0;
      dinMeta <= 1'b0;
      dinSync <= 1'b0;
    end else begin
      csMeta <= csN;
      csSync <= csMeta;
      csLast <= csSync;
      sclkMeta <= sclk;
      sclkSync <= sclkMeta;
      sclkLast <= sclkSync;
      dinMeta <= din;
      dinSync <= dinMeta;
    end
  end

  // with the clock already low, the frame select fall doubles as the first internal falling clock edge
  assign sclkRise = sclkSync && !sclkLast;
  assign sclkFall = !sclkSync && sclkLast;
  assign frameStart = !csSync && csLast;
  assign word = {inputSelectControl[`CTRL_WIDTH-2:0], dinSync};
  // result word is taken at the start of the fifth clock
  assign popReady = !csSync && !frameStart && sclkFall && (cycle == `CYC_HOLD);

  // result buffer: a stalled shifter leaves words here, and a full buffer stalls the core
  sample_fifo #(
    .WIDTH(`RES_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .inValid(convValid),
    .inReady(convReady),
    .inData(convData),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popData)
  );

  // frame sequencing, control word capture and output shifting
  always_comb begin
    next_cycle = cycle;
    next_riseCnt = riseCnt;
    next_inputSelectControl = inputSelectControl;
    next_pendingChan = pendingChan;
    next_activeChan = activeChan;
    next_shifter = shifter;
    next_doutO = doutO;
    next_sampleReq = 1'b0;
    next_sampleChan = sampleChan;
    if (csSync) begin
      next_cycle = `CYC_NONE;
      next_riseCnt = 4'h0;
      next_doutO = 1'b0;
    end else if (frameStart) begin
      // clock already low: this fall is the first falling edge
      next_cycle = sclkSync ? `CYC_NONE : `CYC_FIRST;
      next_riseCnt = 4'h0;
      next_doutO = 1'b0;
    end else begin
      if (sclkRise) begin
        if (riseCnt <= `RISE_CTRL_LAST) begin
          next_inputSelectControl = word;
        end
        if (riseCnt == `RISE_CTRL_LAST) begin
          // only bit 3 is looked at; bit 5 and the spare bits are ignored
          next_pendingChan = word[`CHSEL_LO] ? adc_ctrl_pkg::CHAN_B : adc_ctrl_pkg::CHAN_A;
        end
        if (riseCnt == `RISE_LAST) begin
          next_riseCnt = 4'h0;
          next_activeChan = pendingChan; // takes effect for the next track phase
        end else begin
          next_riseCnt = riseCnt + 4'h1;
        end
      end
      if (sclkFall) begin
        // wrap after sixteen clocks keeps converting while selected
        next_cycle = (cycle == `CYC_LAST || cycle == `CYC_NONE) ? `CYC_FIRST : cycle + 5'h01;
        if (next_cycle == `CYC_HOLD) begin
          next_sampleReq = 1'b1;
          next_sampleChan = activeChan;
          next_doutO = 1'b0;
        end else if (next_cycle == `CYC_MSB) begin
          // empty buffer yields zeros rather than stale data
          next_doutO = popValid ? popData[`RES_WIDTH-1] : 1'b0;
          next_shifter = popValid ? {popData[`RES_WIDTH-2:0], 1'b0} : `RES_ZERO;
        end else if (next_cycle > `CYC_MSB) begin
          next_doutO = shifter[`RES_WIDTH-1];
          next_shifter = {shifter[`RES_WIDTH-2:0], 1'b0};
        end else begin
          next_doutO = 1'b0;
        end
      end
    end
  end

  // power-up state selects input a, no warm-up needed
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cycle <= `CYC_NONE;
      riseCnt <= 4'h0;
      inputSelectControl <= `CTRL_RESET;
      pendingChan <= adc_ctrl_pkg::CHAN_A;
      activeChan <= adc_ctrl_pkg::CHAN_A;
      shifter <= `RES_ZERO;
      doutO <= 1'b0;
      sampleReq <= 1'b0;
      sampleChan <= adc_ctrl_pkg::CHAN_A;
    end else begin
      cycle <= next_cycle;
      riseCnt <= next_riseCnt;
      inputSelectControl <= next_inputSelectControl;
      pendingChan <= next_pendingChan;
      activeChan <= next_activeChan;
      shifter <= next_shifter;
      doutO <= next_doutO;
      sampleReq <= next_sampleReq;
      sampleChan <= next_sampleChan;
    end
  end

  // phase decode from the clock position inside the conversion
  always_comb begin
    case (cycle)
      `CYC_NONE: phase = adc_ctrl_pkg::PH_SLEEP;
      `CYC_LAST: phase = adc_ctrl_pkg::PH_SLEEP;
      `CYC_FIRST, `CYC_TRACK_MID, `CYC_TRACK_LAST: phase = adc_ctrl_pkg::PH_TRACK;
      default: phase = adc_ctrl_pkg::PH_CONVERT;
    endcase
  end

  assign trackMode = (phase == adc_ctrl_pkg::PH_TRACK) && !csSync;
  assign powerDown = csSync || (phase == adc_ctrl_pkg::PH_SLEEP);
  assign doutOe = !csSync;
  assign chanSel = activeChan;

  // helper for the power-up channel check
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      everCommit <= 1'b0;
    end else begin
      everCommit <= everCommit || (sclkRise && riseCnt == `RISE_LAST && !csSync && !frameStart);
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  AST_FIRST_CHAN: assert property (!everCommit |-> chanSel == adc_ctrl_pkg::CHAN_A)
    else $error("first conversion not on input a");
  AST_FRAME_RISE: assert property (frameStart |=> riseCnt == 4'h0 ##0 cycle <= `CYC_FIRST)
    else $error("frame start did not restart counters");
  AST_CTRL_SAMPLE: assert property (sclkRise && !csSync && !frameStart && riseCnt <= `RISE_CTRL_LAST
    |=> inputSelectControl[0] == $past(dinSync))
    else $error("control bit not sampled");
  AST_DECODE: assert property (sclkRise && !csSync && !frameStart && riseCnt == `RISE_CTRL_LAST
    |=> pendingChan == (inputSelectControl[`CHSEL_LO] ? adc_ctrl_pkg::CHAN_B : adc_ctrl_pkg::CHAN_A))
    else $error("channel decode wrong");
  AST_IGNORED: assert property ($changed(pendingChan) |-> $past(sclkRise && riseCnt == `RISE_CTRL_LAST))
    else $error("channel changed outside word end");
  AST_COMMIT: assert property (sclkRise && !csSync && !frameStart && riseCnt == `RISE_LAST
    |=> chanSel == $past(pendingChan) ##0 riseCnt == 4'h0)
    else $error("channel not committed at conversion end");
  AST_HOLD: assert property (sclkFall && !csSync && !frameStart && cycle == `CYC_TRACK_LAST
    |=> !trackMode && sampleReq ##1 !sampleReq)
    else $error("hold not entered after three clocks");
  AST_MSB: assert property (popReady && popValid |=> doutO == $past(popData[`RES_WIDTH-1]))
    else $error("msb not on fifth clock");
  AST_LEAD0: assert property (!csSync && cycle >= `CYC_FIRST && cycle <= `CYC_HOLD |-> !doutO)
    else $error("leading bit not zero");
  AST_WRAP: assert property (sclkFall && !csSync && !frameStart && cycle == `CYC_LAST
    |=> cycle == `CYC_FIRST && trackMode && !powerDown)
    else $error("no back-to-back conversion");
  AST_PD16: assert property (sclkFall && !csSync && !frameStart && cycle == `CYC_PRE_LAST |=> powerDown)
    else $error("no power down after 16th fall");
  AST_OE: assert property ($rose(csSync) |=> !doutOe && powerDown)
    else $error("output not released");
  AST_CNT: assert property (!csSync |-> cycle <= `CYC_LAST)
    else $error("conversion longer than sixteen clocks");
endmodule : dual_adc_serial_ctrl
`default_nettype wire

// ### hdl/sample_fifo.sv
// Purpose: result buffer between the analog core and the serial shifter
// Assumes: one clock, asynchronous active-low reset
// Notes: pointers carry one extra bit so full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic [AW:0] next_wrPtr;
  logic [AW:0] next_rdPtr;
  logic doWrite;
  logic doRead;

  // full when pointers differ only in the wrap bit
  assign inReady = !((wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
  assign outValid = (wrPtr != rdPtr);
  assign outData = mem[rdPtr[AW-1:0]];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // pointer advance
  always_comb begin
    next_wrPtr = doWrite ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doRead ? rdPtr + 1'b1 : rdPtr;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule : sample_fifo
`default_nettype wire

// ### inc/adc_ctrl_pkg.sv
// Purpose: shared types of the converter serial control block
// Assumes: nothing beyond the constant header
// Notes: channel and phase encodings are left to the tools
package adc_ctrl_pkg;
  typedef enum logic {CHAN_A, CHAN_B} chan_t;
  typedef enum logic [1:0] {PH_SLEEP, PH_TRACK, PH_CONVERT} phase_t;
endpackage : adc_ctrl_pkg

// ### inc/adc_ctrl_regs.svh
// Purpose: named constants of the two-input converter serial control block
// Assumes: control word arrives most significant bit first on the serial input
// Notes: types live in adc_ctrl_pkg
//
// How it works
// - simultaneous frame and clock fall: next rise first
// - no warm-up; first result from input a
// - channel-select bits sit at word bits 5..3; only bit 3 is decoded, bits 5 and 4 are ignored
// - bits 7..6 and 2..0 change nothing
// - bits 4..3: 00 input a, 01 input b
// - result is unsigned straight-binary twelve-bit code
// - power down while deselected and after 16th fall
// - sixteen clocks per conversion, back to back allowed
// - conversions repeat while frame select stays low
// - track three clocks, convert twelve, MSB on fifth
// - first eight rising edges carry the control word
// - serial output released while frame select high
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define CTRL_WIDTH 8
`define CTRL_RESET 8'h00
`define CHSEL_HI 5
`define CHSEL_MID 4
`define CHSEL_LO 3
`define RISE_CTRL_LAST 4'h7
`define RISE_LAST 4'hf
`define RES_WIDTH 12
`define RES_ZERO 12'h000
`define CYC_NONE 5'h00
`define CYC_FIRST 5'h01
`define CYC_TRACK_MID 5'h02
`define CYC_TRACK_LAST 5'h03
`define CYC_HOLD 5'h04
`define CYC_MSB 5'h05
`define CYC_LAST 5'h10
`define CYC_PRE_LAST 5'h0f
`define FIFO_DEPTH 32

`endif
